/* socket_status_change_events_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module socket_status_change_events_tb;
    import sscev_pkg::*;
    logic mclk, rst, global_reset_n, bus_reset_n, mem_wr, mem_rd;
    logic mem_rvalid, slow;
    logic [BASE_W-1:0] base [NFUNC];
    logic [ADDR_W-1:0] mem_addr;
    logic [BE_W-1:0] mem_be;
    logic [DATA_W-1:0] mem_wdata, mem_rdata, rd_v;
    logic [NFUNC-1:0] sts, det1, det2, pwr, cb, irq, want_cb;
    logic [7:0] want;
    logic [EV_W-1:0] exp_fl [NFUNC];
    logic [EV_W-1:0] exp_en [NFUNC];
    int n_mismatch, total_checks;

    sscev_top i_dut (
        .mclk(mclk), .rst(rst), .global_reset_n(global_reset_n),
        .bus_reset_n(bus_reset_n), .func0_base(base[0]),
        .func1_base(base[1]), .mem_addr(mem_addr), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .card_status_state(sts), .detect_one_state(det1),
        .detect_two_state(det2), .power_cycle_state(pwr),
        .cardbus_card(cb), .status_change_interrupt(irq)
    );
    sscev_card_model i_card (
        .mclk(mclk), .slow(slow), .want(want), .want_cb(want_cb),
        .card_status_state(sts), .detect_one_state(det1),
        .detect_two_state(det2), .power_cycle_state(pwr),
        .cardbus_card(cb)
    );

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic irq_of(logic [3:0] fl, logic [3:0] en);
        return (fl[3] & en[3]) | ((fl[2] | fl[1]) & (en[2:1] == CD_ENABLE))
            | (fl[0] & en[0]);
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] expect_v,
                       input string what);
        total_checks++;
        if (seen !== expect_v) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, what, seen, expect_v);
        end
    endtask

    task automatic wr(input int f, input sscev_ofs_t ofs,
                      input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        #1;
        mem_addr = {base[f], ofs};
        mem_be = be;
        mem_wdata = d;
        mem_wr = 1'h1;
        @(posedge mclk);
        #1;
        mem_wr = 1'h0;
    endtask

    task automatic rd_a(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        #1;
        mem_addr = a;
        mem_rd = 1'h1;
        @(posedge mclk);
        #1;
        mem_rd = 1'h0;
        chk({31'h0, mem_rvalid}, 32'h1, "read answer");
        d = mem_rdata;
    endtask

    task automatic rdc(input int f, input sscev_ofs_t ofs,
                       input logic [31:0] e, input string what);
        rd_a({base[f], ofs}, rd_v);
        chk(rd_v, e, what);
    endtask

    task automatic check_state(input int f);
        rdc(f, OFS_FLAGS, {28'h0, exp_fl[f]}, "flags");
        rdc(f, OFS_ENABLES, {28'h0, exp_en[f]}, "enables");
        chk({31'h0, irq[f]}, {31'h0, irq_of(exp_fl[f], exp_en[f])},
            "irq");
    endtask

    task automatic set_pin(input int f, input int b, input logic v);
        @(posedge mclk);
        #1;
        want[4*f+b] = v;
        repeat (8) @(posedge mclk);
    endtask

    task automatic pulse(input logic glb);
        @(posedge mclk);
        #1;
        if (glb) global_reset_n = 1'h0;
        else bus_reset_n = 1'h0;
        repeat (4) @(posedge mclk);
        #1;
        global_reset_n = 1'h1;
        bus_reset_n = 1'h1;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        rst = 1'h1;
        global_reset_n = 1'h1;
        bus_reset_n = 1'h1;
        base[0] = 20'hA0000;
        base[1] = 20'hB0000;
        mem_addr = 32'h0;
        mem_wr = 1'h0;
        mem_rd = 1'h0;
        mem_be = 4'h0;
        mem_wdata = 32'h0;
        want = 8'h00;
        want_cb = 2'h0;
        slow = 1'h0;
        n_mismatch = 0;
        total_checks = 0;
        exp_fl = '{4'h0, 4'h0};
        exp_en = '{4'h0, 4'h0};
        void'($urandom(32'h7B7C036E));
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'h0;
        for (int i = 5; i < 8; i++) begin
            wr(1, sscev_ofs_t'(i * 4), 32'hFFFFFFFF, 4'hF);
        end
        for (int f = 0; f < NFUNC; f++) begin
            for (int i = 0; i < 10; i++) begin
                rdc(f, sscev_ofs_t'(i * 4), (i == 2) ? LIVE_FIXED : ZERO,
                    "map");
            end
        end
        rd_a(32'hC0000008, rd_v);
        chk(rd_v, ZERO, "unmapped");
        // reserved bits, set by force, clear by one only
        wr(0, OFS_ENABLES, 32'hFFFFFFFF, 4'hF);
        exp_en[0] = 4'hF;
        wr(0, OFS_INJECT, 32'h0000000F, 4'h1);
        exp_fl[0] = 4'hF;
        check_state(0);
        check_state(1);
        wr(0, OFS_FLAGS, 32'hFFFFFFF0, 4'hF);
        check_state(0);
        wr(0, OFS_FLAGS, 32'h00000005, 4'h1);
        exp_fl[0] = 4'hA;
        check_state(0);
        wr(0, OFS_ENABLES, ZERO, 4'h1);
        exp_en[0] = 4'h0;
        check_state(0);
        // pin changes set flags with every enable off
        for (int f = 0; f < NFUNC; f++) begin
            for (int b = 1; b < 4; b++) begin
                wr(f, OFS_FLAGS, 32'(1 << b), 4'h1);
                exp_fl[f][b] = 1'h0;
                set_pin(f, b, 1'h1);
                exp_fl[f][b] = 1'h1;
                check_state(f);
                rdc(f, OFS_LIVE, LIVE_FIXED | (32'h1 << b), "live");
                set_pin(f, b, 1'h0);
                check_state(f);
            end
            exp_fl[f] = 4'hE;
        end
        for (int c = 0; c < 4; c++) begin
            wr(1, OFS_ENABLES, 32'(c << 1), 4'h1);
            exp_en[1] = 4'(c << 1);
            check_state(1);
        end
        wr(1, OFS_ENABLES, 32'h00000008, 4'h1);
        exp_en[1] = 4'h8;
        check_state(1);
        wr(1, OFS_FLAGS, 32'h00000008, 4'h1);
        exp_fl[1] = 4'h6;
        check_state(1);
        // status edges by card kind, card answering late
        slow = 1'h1;
        for (int cbv = 0; cbv < 2; cbv++) begin
            want_cb[0] = cbv[0];
            wr(0, OFS_FLAGS, 32'h0000000F, 4'h1);
            wr(0, OFS_ENABLES, 32'h00000001, 4'h1);
            exp_fl[0] = 4'h0;
            exp_en[0] = 4'h1;
            set_pin(0, 0, 1'h1);
            exp_fl[0] = 4'h1;
            check_state(0);
            wr(0, OFS_FLAGS, 32'h00000001, 4'h1);
            set_pin(0, 0, 1'h0);
            exp_fl[0] = {3'h0, cbv == 0};
            check_state(0);
        end
        wr(1, OFS_INJECT, 32'h00003C00, 4'h2);
        rdc(1, OFS_LIVE, LIVE_FIXED | 32'h3C00, "injected live");
        // bus reset without and with context kept, then global reset
        wr(0, OFS_CTRL, 32'h000000A5, 4'h1);
        wr(0, OFS_ENABLES, 32'h0000000F, 4'h1);
        set_pin(0, 1, 1'h1);
        pulse(1'h0);
        exp_fl = '{4'h2, 4'h0};
        exp_en = '{4'h0, 4'h0};
        check_state(0);
        check_state(1);
        rdc(0, OFS_CTRL, ZERO, "ctrl bus reset");
        rdc(1, OFS_LIVE, LIVE_FIXED, "live bus reset");
        wr(0, OFS_PWR, 32'h00000001, 4'h1);
        wr(0, OFS_CTRL, 32'h000000A5, 4'h1);
        wr(0, OFS_ENABLES, 32'h0000000F, 4'h1);
        exp_en[0] = 4'hF;
        pulse(1'h0);
        check_state(0);
        rdc(0, OFS_CTRL, 32'h000000A5, "ctrl kept");
        rdc(0, OFS_PWR, 32'h00000001, "pme kept");
        set_pin(0, 1, 1'h0);
        pulse(1'h1);
        exp_fl[0] = 4'h0;
        exp_en[0] = 4'h0;
        check_state(0);
        rdc(0, OFS_CTRL, ZERO, "ctrl global");
        rdc(0, OFS_PWR, ZERO, "pme global");
        // random force, clear and enable traffic
        for (int k = 0; k < 24; k++) begin
            int f;
            logic [3:0] fv, cv, ev;
            f = $urandom_range(1, 0);
            fv = 4'($urandom);
            cv = 4'($urandom);
            ev = 4'($urandom);
            wr(f, OFS_INJECT, {28'h0, fv}, 4'h1);
            wr(f, OFS_FLAGS, {28'($urandom), cv}, 4'h1);
            wr(f, OFS_ENABLES, {28'($urandom), ev}, 4'h1);
            exp_fl[f] = (exp_fl[f] | fv) & ~cv;
            exp_en[f] = ev;
            check_state(f);
        end
        end_of_test();
    end
endmodule
`default_nettype wire

/* sscev_card_model.sv */
`timescale 1ns/1ns
`default_nettype none
// card in the socket: follows the levels asked of it, promptly or a
// cycle late; bit order per function is {power, detect two, detect one,
// status}
module sscev_card_model (
    input wire logic mclk,
    input wire logic slow,
    input wire logic [7:0] want,
    input wire logic [1:0] want_cb,
    output logic [1:0] card_status_state,
    output logic [1:0] detect_one_state,
    output logic [1:0] detect_two_state,
    output logic [1:0] power_cycle_state,
    output logic [1:0] cardbus_card
);
    logic [7:0] stage_q = 8'h00;
    logic [7:0] pins_q = 8'h00;
    logic [1:0] cb_q = 2'h0;
    always @(posedge mclk) begin
        stage_q <= want;
        pins_q <= slow ? stage_q : want;
        cb_q <= want_cb;
    end
    assign card_status_state = {pins_q[4], pins_q[0]};
    assign detect_one_state = {pins_q[5], pins_q[1]};
    assign detect_two_state = {pins_q[6], pins_q[2]};
    assign power_cycle_state = {pins_q[7], pins_q[3]};
    assign cardbus_card = cb_q;
endmodule
`default_nettype wire

/* sscev_pkg.sv */
// How it works
// - six 32-bit socket registers per function, each function behind its own base
// - flags 00h, enables 04h, live 08h, injector 0Ch, controls 10h, power 20h
// - a flag records only that its status changed, not the new value
// - writing one clears a flag, writing zero leaves it alone
// - writing one to the injector bit sets the matching flag
// - bus reset clears flags unless power events are enabled; a status held high sets its flag again on release
// - a set flag raises the interrupt with its enable on; flags 1 and 2 need both detect enable bits on
// - bits 31 to 4 of flags and enables ignore writes, read zero
// - flag 3 sets on any change of the power cycle state
// - flag 2 sets on any change of the second detect state
// - flag 1 sets on any change of the first detect state
// - for a cardbus card flag 0 sets on a rising status edge only
// - for a 16-bit card flag 0 sets on both status edges
// - context bits survive bus reset while power events are enabled
// - enables gate only the interrupt, flags set regardless
// - enable bit 3 lets power cycle changes interrupt, resets to zero
// - detect enable field 11 allows, 00, 01 and 10 suppress
// - enable bit 0 lets card status changes interrupt, resets to zero
// - live state shows bits written through the injector
package sscev_pkg;
    localparam int NFUNC = 2;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int OFS_W = 12;
    localparam int BASE_W = ADDR_W - OFS_W;
    localparam int EV_W = 4;
    localparam int CTRL_W = 8;
    localparam int CSTS_BIT = 0;
    localparam int CD1_BIT = 1;
    localparam int CD2_BIT = 2;
    localparam int PWR_BIT = 3;
    localparam int PME_BIT = 0;
    localparam int INJ_LIVE_LO = 10;
    localparam int INJ_LIVE_W = 4;
    localparam int BE_LO = 0;
    localparam int BE_INJ = 1;
    localparam int SYNC_W = 10;
    localparam int CSTS_LO = 0;
    localparam int CD1_LO = 2;
    localparam int CD2_LO = 4;
    localparam int PWR_LO = 6;
    localparam int SYNC_GLB = 8;
    localparam int SYNC_BUS = 9;
    typedef logic [OFS_W-1:0] sscev_ofs_t;
    localparam sscev_ofs_t OFS_FLAGS = 12'h000;
    localparam sscev_ofs_t OFS_ENABLES = 12'h004;
    localparam sscev_ofs_t OFS_LIVE = 12'h008;
    localparam sscev_ofs_t OFS_INJECT = 12'h00C;
    localparam sscev_ofs_t OFS_CTRL = 12'h010;
    localparam sscev_ofs_t OFS_RSV_LO = 12'h014;
    localparam sscev_ofs_t OFS_RSV_HI = 12'h01C;
    localparam sscev_ofs_t OFS_PWR = 12'h020;
    localparam logic [DATA_W-1:0] ZERO = 32'h0000_0000;
    localparam logic [DATA_W-1:0] LIVE_FIXED = 32'h3000_0000;
    localparam logic [EV_W-1:0] EV_NONE = 4'h0;
    localparam logic [1:0] CD_ENABLE = 2'h3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [INJ_LIVE_W-1:0] INJ_RST = 4'h0;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 10'h300;
endpackage

/* sscev_socket.sv */
`timescale 1ns/1ns
`default_nettype none
module sscev_socket (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ctx_clear,
    input wire logic bus_rst,
    input wire logic cardbus_card,
    input wire logic [sscev_pkg::EV_W-1:0] live,
    input wire logic [sscev_pkg::EV_W-1:0] flag_clr,
    input wire logic [sscev_pkg::EV_W-1:0] flag_force,
    input wire logic mask_wr,
    input wire logic [sscev_pkg::EV_W-1:0] mask_wdata,
    output logic [sscev_pkg::EV_W-1:0] flags,
    output logic [sscev_pkg::EV_W-1:0] enables,
    output logic status_change_interrupt
);
    import sscev_pkg::*;
    logic [EV_W-1:0] prev_q, prev_d, flags_q, flags_d, en_q, en_d;
    logic [EV_W-1:0] chg, hit_w, clr_only;
    logic irq_q, irq_d, irq_pwr, irq_cd, irq_cs;

    always_comb begin
        chg = live ^ prev_q;
        prev_d = bus_rst ? EV_NONE : live;
        hit_w = EV_NONE;
        if (!bus_rst) begin
            hit_w[PWR_BIT] = chg[PWR_BIT];
            hit_w[CD2_BIT] = chg[CD2_BIT];
            hit_w[CD1_BIT] = chg[CD1_BIT];
            if (cardbus_card) begin
                hit_w[CSTS_BIT] = live[CSTS_BIT] & ~prev_q[CSTS_BIT];
            end else begin
                hit_w[CSTS_BIT] = chg[CSTS_BIT];
            end
        end
        // set beats clear, mask plays no part
        flags_d = (flags_q & ~flag_clr) | hit_w | flag_force;
        en_d = mask_wr ? mask_wdata : en_q;
        if (ctx_clear) begin
            flags_d = EV_NONE;
            en_d = EV_NONE;
        end
        irq_pwr = flags_q[PWR_BIT] & en_q[PWR_BIT];
        irq_cd = (flags_q[CD1_BIT] | flags_q[CD2_BIT])
            & (en_q[CD2_BIT:CD1_BIT] == CD_ENABLE);
        irq_cs = flags_q[CSTS_BIT] & en_q[CSTS_BIT];
        irq_d = irq_pwr | irq_cd | irq_cs;
        clr_only = flag_clr & ~hit_w & ~flag_force;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_q <= EV_NONE;
            flags_q <= EV_NONE;
            en_q <= EV_NONE;
            irq_q <= 1'h0;
        end else begin
            prev_q <= prev_d;
            flags_q <= flags_d;
            en_q <= en_d;
            irq_q <= irq_d;
        end
    end

    assign flags = flags_q;
    assign enables = en_q;
    assign status_change_interrupt = irq_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_pending;
        irq_pwr || irq_cd || irq_cs;
    endsequence
    sequence s_rst_release;
        bus_rst ##1 !bus_rst && !ctx_clear && live[CD1_BIT];
    endsequence

    a_flag_sets_unmasked: assert property (
        !ctx_clear && hit_w != EV_NONE
        |=> (flags_q & $past(hit_w)) == $past(hit_w)
    ) else $error("change did not set its flag");
    a_force_sets_flag: assert property (
        !ctx_clear && flag_force != EV_NONE
        |=> (flags_q & $past(flag_force)) == $past(flag_force)
    ) else $error("forced flag not set");
    a_one_clears_flag: assert property (
        !ctx_clear && clr_only != EV_NONE
        |=> (flags_q & $past(clr_only)) == EV_NONE
    ) else $error("write of one did not clear flag");
    a_ctx_clear_all: assert property (
        ctx_clear |=> flags_q == EV_NONE && en_q == EV_NONE
    ) else $error("context clear left bits set");
    a_refire_release: assert property (
        s_rst_release |=> flags_q[CD1_BIT]
    ) else $error("detect flag did not set after bus reset");
    a_cb_no_fall: assert property (
        cardbus_card && prev_q[CSTS_BIT] && !live[CSTS_BIT]
        && !flags_q[CSTS_BIT] && !flag_force[CSTS_BIT]
        |=> !flags_q[CSTS_BIT]
    ) else $error("cardbus falling edge set status flag");
    a_pc_both_edges: assert property (
        !cardbus_card && !bus_rst && !ctx_clear
        && live[CSTS_BIT] != prev_q[CSTS_BIT]
        |=> flags_q[CSTS_BIT]
    ) else $error("16-bit card edge missed");
    a_detect_two: assert property (
        !bus_rst && !ctx_clear && chg[CD2_BIT] |=> flags_q[CD2_BIT]
    ) else $error("second detect change missed");
    a_power_cycle: assert property (
        !bus_rst && !ctx_clear && chg[PWR_BIT] |=> flags_q[PWR_BIT]
    ) else $error("power cycle change missed");
    a_irq_raised: assert property (
        s_pending |=> status_change_interrupt
    ) else $error("pending enabled flag gave no interrupt");
    a_irq_quiet: assert property (
        !irq_pwr && !irq_cd && !irq_cs |=> !status_change_interrupt
    ) else $error("interrupt without enabled flag");
endmodule
`default_nettype wire

/* sscev_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sscev_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic global_reset_n,
    input wire logic bus_reset_n,
    input wire logic [sscev_pkg::BASE_W-1:0] func0_base,
    input wire logic [sscev_pkg::BASE_W-1:0] func1_base,
    input wire logic [sscev_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [sscev_pkg::BE_W-1:0] mem_be,
    input wire logic [sscev_pkg::DATA_W-1:0] mem_wdata,
    output logic [sscev_pkg::DATA_W-1:0] mem_rdata,
    output logic mem_rvalid,
    input wire logic [sscev_pkg::NFUNC-1:0] card_status_state,
    input wire logic [sscev_pkg::NFUNC-1:0] detect_one_state,
    input wire logic [sscev_pkg::NFUNC-1:0] detect_two_state,
    input wire logic [sscev_pkg::NFUNC-1:0] power_cycle_state,
    input wire logic [sscev_pkg::NFUNC-1:0] cardbus_card,
    output logic [sscev_pkg::NFUNC-1:0] status_change_interrupt
);
    import sscev_pkg::*;

    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s1_d;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s2_d;
    logic glb;
    logic busr;

    logic [OFS_W-1:0] ofs;
    logic [NFUNC-1:0] hit;
    logic [NFUNC-1:0] sel;
    logic [NFUNC-1:0] wr_lo;
    logic [NFUNC-1:0] wr_inj;
    logic [NFUNC-1:0] mask_wr;
    logic [NFUNC-1:0] ctx_clear;
    logic rf;

    logic [EV_W-1:0] live [NFUNC];
    logic [EV_W-1:0] flag_clr [NFUNC];
    logic [EV_W-1:0] flag_force [NFUNC];
    logic [EV_W-1:0] flags_w [NFUNC];
    logic [EV_W-1:0] en_w [NFUNC];
    logic [EV_W-1:0] mask_wdata;

    logic [NFUNC-1:0] pme_q;
    logic [NFUNC-1:0] pme_d;
    logic [CTRL_W-1:0] ctrl_q [NFUNC];
    logic [CTRL_W-1:0] ctrl_d [NFUNC];
    logic [INJ_LIVE_W-1:0] inj_q [NFUNC];
    logic [INJ_LIVE_W-1:0] inj_d [NFUNC];
    logic [INJ_LIVE_W-1:0] inj_w;

    logic [DATA_W-1:0] rd_w;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic chk_q;
    logic chk_d;

    // pin synchronisers
    always_comb begin
        s1_d = {
            bus_reset_n,
            global_reset_n,
            power_cycle_state,
            detect_two_state,
            detect_one_state,
            card_status_state
        };
        s2_d = s1_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign glb = ~s2_q[SYNC_GLB];
    assign busr = ~s2_q[SYNC_BUS];
    assign mask_wdata = mem_wdata[EV_W-1:0];
    assign inj_w = mem_wdata[INJ_LIVE_LO +: INJ_LIVE_W];

    // window decode and write strobes
    always_comb begin
        ofs = mem_addr[OFS_W-1:0];
        hit[0] = mem_addr[ADDR_W-1:OFS_W] == func0_base;
        hit[1] = mem_addr[ADDR_W-1:OFS_W] == func1_base;
        sel[0] = hit[0];
        sel[1] = hit[1] & ~hit[0];
        rf = sel[1];
        for (int f = 0; f < NFUNC; f++) begin
            live[f] = {
                s2_q[PWR_LO + f],
                s2_q[CD2_LO + f],
                s2_q[CD1_LO + f],
                s2_q[CSTS_LO + f]
            };
            wr_lo[f] = mem_wr & sel[f] & mem_be[BE_LO];
            wr_inj[f] = mem_wr & sel[f] & mem_be[BE_INJ];
            flag_clr[f] = EV_NONE;
            if (wr_lo[f] && ofs == OFS_FLAGS) begin
                flag_clr[f] = mem_wdata[EV_W-1:0];
            end
            flag_force[f] = EV_NONE;
            if (wr_lo[f] && ofs == OFS_INJECT) begin
                flag_force[f] = mem_wdata[EV_W-1:0];
            end
            mask_wr[f] = wr_lo[f] && ofs == OFS_ENABLES;
        end
    end

    // controls, power and injected live bits
    always_comb begin
        for (int f = 0; f < NFUNC; f++) begin
            ctx_clear[f] = glb | (busr & ~pme_q[f]);
            pme_d[f] = pme_q[f];
            if (wr_lo[f] && ofs == OFS_PWR) begin
                pme_d[f] = mem_wdata[PME_BIT];
            end
            if (glb) begin
                pme_d[f] = 1'h0;
            end
            ctrl_d[f] = ctrl_q[f];
            if (wr_lo[f] && ofs == OFS_CTRL) begin
                ctrl_d[f] = mem_wdata[CTRL_W-1:0];
            end
            if (ctx_clear[f]) begin
                ctrl_d[f] = CTRL_RST;
            end
            inj_d[f] = inj_q[f];
            if (wr_inj[f] && ofs == OFS_INJECT) begin
                inj_d[f] = inj_q[f] | inj_w;
            end
            if (glb || busr) begin
                inj_d[f] = INJ_RST;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pme_q <= {NFUNC{1'h0}};
            for (int f = 0; f < NFUNC; f++) begin
                ctrl_q[f] <= CTRL_RST;
                inj_q[f] <= INJ_RST;
            end
        end else begin
            pme_q <= pme_d;
            for (int f = 0; f < NFUNC; f++) begin
                ctrl_q[f] <= ctrl_d[f];
                inj_q[f] <= inj_d[f];
            end
        end
    end

    // read data, one cycle after the strobe
    always_comb begin
        rd_w = ZERO;
        if (|hit) begin
            case (ofs)
                OFS_FLAGS: begin
                    rd_w = DATA_W'(flags_w[rf]);
                end
                OFS_ENABLES: begin
                    rd_w = DATA_W'(en_w[rf]);
                end
                OFS_LIVE: begin
                    rd_w = LIVE_FIXED
                        | (DATA_W'(inj_q[rf]) << INJ_LIVE_LO)
                        | DATA_W'(live[rf]);
                end
                OFS_CTRL: begin
                    rd_w = DATA_W'(ctrl_q[rf]);
                end
                OFS_PWR: begin
                    rd_w = DATA_W'(pme_q[rf]) << PME_BIT;
                end
                default: begin
                    rd_w = ZERO;
                end
            endcase
        end
        rdata_d = mem_rd ? rd_w : rdata_q;
        rvalid_d = mem_rd;
        chk_d = mem_rd && (|hit)
            && (ofs == OFS_FLAGS || ofs == OFS_ENABLES);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= ZERO;
            rvalid_q <= 1'h0;
            chk_q <= 1'h0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            chk_q <= chk_d;
        end
    end

    assign mem_rdata = rdata_q;
    assign mem_rvalid = rvalid_q;

    // one event block per function
    for (genvar g = 0; g < NFUNC; g++) begin : g_sock
        sscev_socket u_sock (
            .mclk(mclk),
            .rst(rst),
            .ctx_clear(ctx_clear[g]),
            .bus_rst(busr),
            .cardbus_card(cardbus_card[g]),
            .live(live[g]),
            .flag_clr(flag_clr[g]),
            .flag_force(flag_force[g]),
            .mask_wr(mask_wr[g]),
            .mask_wdata(mask_wdata),
            .flags(flags_w[g]),
            .enables(en_w[g]),
            .status_change_interrupt(status_change_interrupt[g])
        );
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_bus_only;
        busr && !glb && pme_q[0] && !mem_wr;
    endsequence
    sequence s_inj_write;
        mem_wr && sel[0] && mem_be[BE_INJ] && ofs == OFS_INJECT
        && !glb && !busr;
    endsequence

    a_unmapped_write: assert property (
        mem_wr && !(|hit) && !glb && !busr
        |=> ctrl_q[0] == $past(ctrl_q[0])
        && ctrl_q[1] == $past(ctrl_q[1])
        && pme_q == $past(pme_q)
    ) else $error("write outside both windows changed state");
    a_func_isolated: assert property (
        mem_wr && sel[0] && ofs == OFS_CTRL && !glb && !busr
        |=> ctrl_q[1] == $past(ctrl_q[1])
    ) else $error("function 0 write reached function 1");
    a_reserved_gap: assert property (
        mem_rd && ofs >= OFS_RSV_LO && ofs <= OFS_RSV_HI
        |=> mem_rvalid && mem_rdata == ZERO
    ) else $error("reserved offset read not zero");
    a_live_fixed: assert property (
        mem_rd && (|hit) && ofs == OFS_LIVE
        |=> mem_rvalid && (mem_rdata & LIVE_FIXED) == LIVE_FIXED
    ) else $error("live state read lost fixed bits");
    a_high_bits_zero: assert property (
        mem_rvalid && chk_q
        |-> mem_rdata[DATA_W-1:EV_W] == ZERO[DATA_W-1:EV_W]
    ) else $error("upper flag or enable bits not zero");
    a_pme_keeps_ctrl: assert property (
        s_bus_only |=> ctrl_q[0] == $past(ctrl_q[0])
    ) else $error("bus reset cleared kept context");
    a_bus_clears_ctrl: assert property (
        busr && !pme_q[0] |=> ctrl_q[0] == CTRL_RST
    ) else $error("bus reset left context set");
    a_live_forced: assert property (
        s_inj_write |=> (inj_q[0] & $past(inj_w)) == $past(inj_w)
    ) else $error("injected live bit not reflected");
endmodule
`default_nettype wire
